// [core/dmm_core.v]
// Functional notes
// - Internal ROM decoded at 0000H..0FFFH.
// - Reset start address read from 0FFCH.
// - Three interrupt vectors at 0FFDH..0FFFH.
// - External variant: 64K space, vectors FFFCH..FFFFH.
// - 512 data words as two 256-word banks.
// - Low bank 0-255, high bank 256-511.
// - Three pointers per bank, own bank only.
// - Pointers 8-bit, read/written via bus low byte.
// - Pointer updates wrap modulo within bank.
// - Indirect, direct and short direct addressing.
// - One cycle per word; only pointer changes.
// - Dual fetch loads both multiplier inputs together.
// - Up to eight external registers, single access.
// - External select latched; strobe, wait, direction.
`timescale 1ns/10ps
`include "dmm_defs.vh"
`default_nettype none

module dmm_core #(
	parameter EXT_PROG = 0
) (
	// Clock and reset
	input wire sys_clk,
	input wire resetn,
	// Program fetch
	input wire fetch_req,
	input wire [15:0] fetch_addr,
	input wire irq_req,
	input wire [1:0] irq_idx,
	output reg prog_busy_ff,
	output reg [15:0] prog_data_ff,
	output reg prog_valid_ff,
	output reg [15:0] start_addr_ff,
	output reg start_valid_ff,
	output reg [15:0] vec_addr_ff,
	output reg vec_valid_ff,
	// Internal ROM load
	input wire rom_load_en,
	input wire [11:0] rom_load_addr,
	input wire [15:0] rom_load_data,
	// External program memory pins
	output reg [15:0] prog_pin_addr_ff,
	input wire [15:0] prog_pin_data,
	// Data storage access
	input wire dm_req,
	input wire dm_we,
	input wire [1:0] dm_mode,
	input wire [8:0] dm_addr,
	input wire [3:0] dm_short,
	input wire dm_bank,
	input wire [1:0] dm_ptr_idx,
	input wire [1:0] dm_ptr_mod,
	input wire [15:0] dm_wdata,
	output reg [15:0] dm_rdata_ff,
	output reg dm_valid_ff,
	// Dual operand fetch
	input wire dual_req,
	input wire [1:0] dual_idx_low,
	input wire [1:0] dual_idx_high,
	input wire [1:0] dual_mod,
	output reg [15:0] xin_ff,
	output reg [15:0] yin_ff,
	output reg xy_valid_ff,
	// Pointer register access
	input wire ptr_wr,
	input wire ptr_rd,
	input wire ptr_bank,
	input wire [1:0] ptr_idx,
	input wire [15:0] ptr_wdata,
	output reg [15:0] ptr_rdata_ff,
	output reg ptr_valid_ff,
	// External register request
	input wire ext_req,
	input wire ext_we,
	input wire [2:0] ext_sel,
	input wire [15:0] ext_wdata,
	output reg ext_busy_ff,
	output reg [15:0] ext_rdata_ff,
	output reg ext_done_ff,
	// External register pins
	output reg [2:0] ext_register_select_ff,
	output reg data_strobe_n_ff,
	output reg ext_read_ff,
	output reg [15:0] ext_bus_out_ff,
	output reg ext_bus_oe_ff,
	input wire [15:0] ext_bus_in,
	input wire ext_wait
);

// ----------------------------------------------------------------
// Reset release
// ----------------------------------------------------------------
reg rst_meta_ff;
reg rst_sync_ff;
wire rst_n = rst_sync_ff;

always @(posedge sys_clk or negedge resetn) begin
	if (!resetn) begin
		rst_meta_ff <= 1'b0;
		rst_sync_ff <= 1'b0;
	end else begin
		rst_meta_ff <= 1'b1;
		rst_sync_ff <= rst_meta_ff;
	end
end

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
reg [15:0] pd_meta_ff, pd_sync_ff;
reg [15:0] eb_meta_ff, eb_sync_ff;
reg wait_meta_ff, wait_sync_ff;

always @(posedge sys_clk or negedge rst_n) begin
	if (!rst_n) begin
		pd_meta_ff <= 16'h0000;
		pd_sync_ff <= 16'h0000;
		eb_meta_ff <= 16'h0000;
		eb_sync_ff <= 16'h0000;
		wait_meta_ff <= 1'b0;
		wait_sync_ff <= 1'b0;
	end else begin
		pd_meta_ff <= prog_pin_data;
		pd_sync_ff <= pd_meta_ff;
		eb_meta_ff <= ext_bus_in;
		eb_sync_ff <= eb_meta_ff;
		wait_meta_ff <= ext_wait;
		wait_sync_ff <= wait_meta_ff;
	end
end

// ----------------------------------------------------------------
// Program space
// ----------------------------------------------------------------
localparam P_BOOT = 4'h1;
localparam P_IDLE = 4'h2;
localparam P_INT = 4'h4;
localparam P_EXT = 4'h8;
localparam K_BOOT = 2'h0;
localparam K_IRQ = 2'h1;
localparam K_FETCH = 2'h2;

// Masked ROM contents arrive through the load port before release
reg [15:0] rom_mem [0:`DMM_ROM_DEPTH-1];
reg [3:0] pst_ff;
reg [1:0] kind_ff;
reg [15:0] fa_ff;
reg [1:0] pcnt_ff;
wire [15:0] rst_vec = EXT_PROG ? `DMM_RST_VEC_EXT : `DMM_RST_VEC_INT;
wire [15:0] irq_base = EXT_PROG ? `DMM_IRQ_VEC_EXT : `DMM_IRQ_VEC_INT;
// Index 3 has no vector; it is folded onto the lowest-priority one
wire [1:0] irq_sel = (irq_idx == 2'h3) ? 2'h2 : irq_idx;
wire [15:0] irq_vec = irq_base + {14'h0000, irq_sel};
// Outside the internal region the internal variant reads zero
wire rom_hit = (fa_ff <= `DMM_ROM_LAST);
wire [15:0] rom_word = rom_hit ? rom_mem[fa_ff[11:0]] : 16'h0000;

always @(posedge sys_clk) begin
	if (rom_load_en) begin
		rom_mem[rom_load_addr] <= rom_load_data;
	end
end

always @(posedge sys_clk or negedge rst_n) begin
	if (!rst_n) begin
		pst_ff <= P_BOOT;
		kind_ff <= K_BOOT;
		fa_ff <= 16'h0000;
		pcnt_ff <= 2'h0;
		prog_busy_ff <= 1'b1;
		prog_data_ff <= 16'h0000;
		prog_valid_ff <= 1'b0;
		start_addr_ff <= 16'h0000;
		start_valid_ff <= 1'b0;
		vec_addr_ff <= 16'h0000;
		vec_valid_ff <= 1'b0;
		prog_pin_addr_ff <= 16'h0000;
	end else begin
		prog_valid_ff <= 1'b0;
		start_valid_ff <= 1'b0;
		vec_valid_ff <= 1'b0;
		case (pst_ff)
		P_BOOT: begin
			kind_ff <= K_BOOT;
			fa_ff <= rst_vec;
			prog_pin_addr_ff <= rst_vec;
			pcnt_ff <= 2'h0;
			pst_ff <= EXT_PROG ? P_EXT : P_INT;
		end
		P_IDLE: begin
			// Interrupt entry outranks an ordinary fetch
			if (irq_req || fetch_req) begin
				kind_ff <= irq_req ? K_IRQ : K_FETCH;
				fa_ff <= irq_req ? irq_vec : fetch_addr;
				prog_pin_addr_ff <= irq_req ? irq_vec : fetch_addr;
				pcnt_ff <= 2'h0;
				prog_busy_ff <= 1'b1;
				pst_ff <= EXT_PROG ? P_EXT : P_INT;
			end
		end
		P_INT, P_EXT: begin
			// External words need the two sync stages plus a settle cycle
			if (pst_ff == P_INT || pcnt_ff == `DMM_EXT_PROG_CYC) begin
				case (kind_ff)
				K_BOOT: begin
					start_addr_ff <= EXT_PROG ? pd_sync_ff : rom_word;
					start_valid_ff <= 1'b1;
				end
				K_IRQ: begin
					vec_addr_ff <= EXT_PROG ? pd_sync_ff : rom_word;
					vec_valid_ff <= 1'b1;
				end
				default: begin
					prog_data_ff <= EXT_PROG ? pd_sync_ff : rom_word;
					prog_valid_ff <= 1'b1;
				end
				endcase
				prog_busy_ff <= 1'b0;
				pst_ff <= P_IDLE;
			end else begin
				pcnt_ff <= pcnt_ff + 2'h1;
			end
		end
		default: begin
			pst_ff <= P_BOOT;
		end
		endcase
	end
end

// ----------------------------------------------------------------
// Data banks and pointers
// ----------------------------------------------------------------
wire [15:0] bank_rd [0:1];
wire [7:0] ptr_view [0:1];

genvar b;
generate
for (b = 0; b < 2; b = b + 1) begin : g_bank
	reg [15:0] mem [0:`DMM_BANK_DEPTH-1];
	reg [7:0] ptr_ff [0:`DMM_PTR_PER_BANK-1];
	wire dir = (dm_mode == `DMM_MODE_DIR);
	wire hit = dir ? (dm_addr[`DMM_BANK_SEL_BIT] == b) : (dm_bank == b);
	wire [1:0] idx = dual_req ? (b ? dual_idx_high : dual_idx_low) : dm_ptr_idx;
	wire [1:0] mod = dual_req ? dual_mod : dm_ptr_mod;
	wire ind = dual_req || (dm_mode == `DMM_MODE_IND);
	wire cur = dual_req || (dm_req && hit);
	// Index 3 names no pointer, so such an access is dropped
	wire ok = cur && !(ind && idx == 2'h3);
	wire [7:0] pval = ptr_ff[(idx == 2'h3) ? 2'h0 : idx];
	wire [7:0] addr = ind ? pval :
		dir ? dm_addr[7:0] : {4'h0, dm_short};
	wire we = ok && !dual_req && dm_we;
	assign bank_rd[b] = mem[addr];
	assign ptr_view[b] = ptr_ff[(ptr_idx == 2'h3) ? 2'h0 : ptr_idx];

	always @(posedge sys_clk) begin
		if (we) begin
			mem[addr] <= dm_wdata;
		end
	end

	genvar p;
	for (p = 0; p < `DMM_PTR_PER_BANK; p = p + 1) begin : g_ptr
		always @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				ptr_ff[p] <= `DMM_PTR_RST;
			end else if (ptr_wr && ptr_bank == b && ptr_idx == p) begin
				ptr_ff[p] <= ptr_wdata[7:0];
			end else if (ok && ind && idx == p) begin
				// 8-bit add wraps inside the bank for circular buffers
				if (mod == `DMM_MOD_INC) begin
					ptr_ff[p] <= ptr_ff[p] + 8'h01;
				end else if (mod == `DMM_MOD_DEC) begin
					ptr_ff[p] <= ptr_ff[p] - 8'h01;
				end
			end
		end
	end
end
endgenerate

wire dm_go = dm_req && !dual_req &&
	(dm_mode == `DMM_MODE_IND ? g_bank[0].ok || g_bank[1].ok : 1'b1);
wire dm_hi = (dm_mode == `DMM_MODE_DIR) ? dm_addr[`DMM_BANK_SEL_BIT] : dm_bank;

always @(posedge sys_clk or negedge rst_n) begin
	if (!rst_n) begin
		dm_rdata_ff <= 16'h0000;
		dm_valid_ff <= 1'b0;
		xin_ff <= 16'h0000;
		yin_ff <= 16'h0000;
		xy_valid_ff <= 1'b0;
		ptr_rdata_ff <= 16'h0000;
		ptr_valid_ff <= 1'b0;
	end else begin
		// Dual fetch owns both banks, so a single access beside it drops
		dm_valid_ff <= dm_go && !dm_we;
		if (dm_go && !dm_we) begin
			dm_rdata_ff <= dm_hi ? bank_rd[1] : bank_rd[0];
		end
		xy_valid_ff <= dual_req && g_bank[0].ok && g_bank[1].ok;
		if (dual_req && g_bank[0].ok && g_bank[1].ok) begin
			xin_ff <= bank_rd[0];
			yin_ff <= bank_rd[1];
		end
		ptr_valid_ff <= ptr_rd && ptr_idx != 2'h3;
		if (ptr_rd && ptr_idx != 2'h3) begin
			ptr_rdata_ff <= {8'h00, ptr_view[ptr_bank]};
		end
	end
end

// ----------------------------------------------------------------
// External registers
// ----------------------------------------------------------------
reg [1:0] ecnt_ff;

always @(posedge sys_clk or negedge rst_n) begin
	if (!rst_n) begin
		ecnt_ff <= 2'h0;
		ext_busy_ff <= 1'b0;
		ext_rdata_ff <= 16'h0000;
		ext_done_ff <= 1'b0;
		ext_register_select_ff <= 3'h0;
		data_strobe_n_ff <= 1'b1;
		ext_read_ff <= 1'b1;
		ext_bus_out_ff <= 16'h0000;
		ext_bus_oe_ff <= 1'b0;
	end else begin
		ext_done_ff <= 1'b0;
		if (!ext_busy_ff) begin
			if (ext_req) begin
				ext_register_select_ff <= ext_sel;
				ext_read_ff <= !ext_we;
				ext_bus_out_ff <= ext_wdata;
				ext_bus_oe_ff <= ext_we;
				data_strobe_n_ff <= 1'b0;
				ecnt_ff <= 2'h0;
				ext_busy_ff <= 1'b1;
			end
		end else if (ecnt_ff != `DMM_SYNC_CYC) begin
			// Wait is only meaningful once it has crossed both stages
			ecnt_ff <= ecnt_ff + 2'h1;
		end else if (!wait_sync_ff) begin
			if (ext_read_ff) begin
				ext_rdata_ff <= eb_sync_ff;
			end
			data_strobe_n_ff <= 1'b1;
			ext_bus_oe_ff <= 1'b0;
			ext_read_ff <= 1'b1;
			ext_busy_ff <= 1'b0;
			ext_done_ff <= 1'b1;
		end
	end
end

endmodule

`default_nettype wire

// [core/dmm_defs.vh]
`ifndef DMM_DEFS_VH
`define DMM_DEFS_VH

// ----------------------------------------------------------------
// Program space
// ----------------------------------------------------------------
`define DMM_ROM_DEPTH 4096
`define DMM_ROM_FIRST 16'h0000
`define DMM_ROM_LAST 16'h0FFF
`define DMM_USER_LAST 16'h0FFB
`define DMM_RST_VEC_INT 16'h0FFC
`define DMM_IRQ_VEC_INT 16'h0FFD
`define DMM_RST_VEC_EXT 16'hFFFC
`define DMM_IRQ_VEC_EXT 16'hFFFD
`define DMM_IRQ_COUNT 3

// ----------------------------------------------------------------
// Data storage
// ----------------------------------------------------------------
`define DMM_BANK_DEPTH 256
`define DMM_BANK_SEL_BIT 8
`define DMM_PTR_PER_BANK 3
`define DMM_PTR_RST 8'h00
`define DMM_MODE_IND 2'h0
`define DMM_MODE_DIR 2'h1
`define DMM_MODE_SHORT 2'h2
`define DMM_MOD_NONE 2'h0
`define DMM_MOD_INC 2'h1
`define DMM_MOD_DEC 2'h2

// ----------------------------------------------------------------
// Pin timing in cycles
// ----------------------------------------------------------------
`define DMM_SYNC_CYC 2'h2
`define DMM_EXT_PROG_CYC 2'h3

`endif

// [verification/dmm_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module dmm_checker (
	// Watched ports
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic fetch_req,
	input wire logic irq_req,
	input wire logic prog_busy_ff,
	input wire logic prog_valid_ff,
	input wire logic vec_valid_ff,
	input wire logic dm_req,
	input wire logic dm_we,
	input wire logic [1:0] dm_ptr_idx,
	input wire logic dual_req,
	input wire logic dm_valid_ff,
	input wire logic xy_valid_ff,
	input wire logic ptr_rd,
	input wire logic ptr_valid_ff,
	input wire logic [15:0] ptr_rdata_ff,
	input wire logic ext_req,
	input wire logic [2:0] ext_sel,
	input wire logic ext_busy_ff,
	input wire logic ext_done_ff,
	input wire logic [2:0] ext_register_select_ff,
	input wire logic data_strobe_n_ff,
	input wire logic ext_read_ff,
	input wire logic ext_bus_oe_ff,
	input wire logic ext_wait
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	chk_fetch_ans: assert property (fetch_req && !irq_req && !prog_busy_ff
		|=> prog_busy_ff ##1 prog_valid_ff) else $error("fetch answer late");
	chk_irq_ans: assert property (irq_req && !prog_busy_ff
		|=> prog_busy_ff ##1 vec_valid_ff) else $error("vector answer late");
	chk_dm_read: assert property (dm_req && !dm_we && !dual_req
		&& dm_ptr_idx != 2'h3 |=> dm_valid_ff) else $error("read late");
	chk_dual_load: assert property (dual_req |=> xy_valid_ff)
		else $error("dual load late");
	chk_ptr_byte: assert property (ptr_rd |=> ptr_valid_ff
		&& ptr_rdata_ff[15:8] == 8'h00) else $error("pointer read bad");
	chk_ext_start: assert property (ext_req && !ext_busy_ff
		|=> !data_strobe_n_ff && ext_register_select_ff == $past(ext_sel))
		else $error("ext start bad");
	chk_ext_min: assert property ($fell(data_strobe_n_ff)
		|-> !ext_done_ff [*3]) else $error("ext access too short");
	chk_ext_end: assert property ($fell(data_strobe_n_ff)
		|-> ##[3:40] ext_done_ff) else $error("ext access hangs");
	chk_sel_hold: assert property (!data_strobe_n_ff
		&& !$past(data_strobe_n_ff) |-> $stable(ext_register_select_ff))
		else $error("select moved");
	chk_oe_dir: assert property (ext_bus_oe_ff
		|-> !ext_read_ff && !data_strobe_n_ff) else $error("oe bad");
	cover property (ext_wait && !data_strobe_n_ff);
	cover property (xy_valid_ff);
	cover property (vec_valid_ff);
endmodule
`default_nettype wire

// [verification/dmm_ext_model.sv]
`timescale 1ns/10ps
`default_nettype none
module dmm_ext_model (
	// Pins from the device
	input wire logic sys_clk,
	input wire logic [2:0] ext_register_select_ff,
	input wire logic data_strobe_n_ff,
	input wire logic ext_read_ff,
	input wire logic [15:0] ext_bus_out_ff,
	input wire logic ext_bus_oe_ff,
	// Pins to the device
	output logic [15:0] ext_bus_in,
	output logic ext_wait
);
	logic [15:0] regs_ff [8];
	logic [15:0] last_ff = 16'h0000;
	logic [3:0] cnt_ff = 4'h0;
	// Idle bus toggles so a stale sample never looks right
	assign ext_bus_in = (!data_strobe_n_ff && ext_read_ff) ?
		regs_ff[ext_register_select_ff] : ~last_ff;
	// Register 5 is slow and holds the wait pin
	assign ext_wait = !data_strobe_n_ff &&
		ext_register_select_ff == 3'h5 && cnt_ff < 4'h4;
	always @(posedge sys_clk) begin
		last_ff <= ext_bus_in;
		cnt_ff <= data_strobe_n_ff ? 4'h0 : cnt_ff + 4'h1;
		if (!data_strobe_n_ff && ext_bus_oe_ff) begin
			regs_ff[ext_register_select_ff] <= ext_bus_out_ff;
		end
	end
endmodule
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/10ps
`include "dmm_defs.vh"
`default_nettype none
module testbench;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic fetch_req, irq_req, rom_load_en, dm_req, dm_we, dm_bank, dual_req;
	logic ptr_wr, ptr_rd, ptr_bank, ext_req, ext_we, ext_wait, erd;
	logic [1:0] irq_idx, dm_mode, dm_ptr_idx, dm_ptr_mod, ptr_idx;
	logic [1:0] dual_idx_low, dual_idx_high, dual_mod;
	logic [2:0] ext_sel, ext_register_select_ff;
	logic [3:0] dm_short;
	logic [8:0] dm_addr;
	logic [11:0] rom_load_addr;
	logic [15:0] fetch_addr, rom_load_data, prog_pin_data, dm_wdata;
	logic [15:0] ptr_wdata, ext_wdata, ext_bus_in, prog_data_ff;
	logic [15:0] start_addr_ff, vec_addr_ff, prog_pin_addr_ff, dm_rdata_ff;
	logic [15:0] xin_ff, yin_ff, ptr_rdata_ff, ext_rdata_ff, ext_bus_out_ff;
	logic prog_busy_ff, prog_valid_ff, start_valid_ff, vec_valid_ff;
	logic dm_valid_ff, xy_valid_ff, ptr_valid_ff, ext_busy_ff, ext_done_ff;
	logic data_strobe_n_ff, ext_read_ff, ext_bus_oe_ff;
	int failures = 0;
	int checks = 0;
	logic [15:0] qp[$], qd[$], qx[$], qr[$], qe[$], qv[$], qa[$];
	logic [15:0] rm[int], m[int];
	int ra[6] = '{0, 'hFFB, 'hFFC, 'hFFD, 'hFFE, 'hFFF};
	int da[6] = '{0, 255, 256, 257, 259, 511};
	dmm_core i_dmm_core (.*);
	dmm_ext_model i_dmm_ext_model (.*);
	always #5 sys_clk = ~sys_clk;
	task tick; @(posedge sys_clk); #1; endtask
	task fail_note(input string s);
		failures++;
		$display("MISMATCH %0t %s", $time, s);
	endtask
	task cmp(input logic [15:0] e, input logic [15:0] g, input string s);
		checks++;
		if (g !== e) fail_note($sformatf("%s exp %h got %h", s, e, g));
	endtask
	task cmp_prog(input logic [15:0] e, input logic [15:0] g);
		cmp(e, g, "program word");
	endtask
	task cmp_vec(input logic [15:0] e, input logic [15:0] g);
		cmp(e, g, "vector word");
	endtask
	task cmp_pa(input logic [15:0] e, input logic [15:0] g);
		cmp(e, g, "program pin address");
	endtask
	task cmp_data(input logic [15:0] e, input logic [15:0] g);
		cmp(e, g, "data word");
	endtask
	task cmp_xy(input logic [15:0] e, input logic [15:0] g);
		cmp(e, g, "multiplier input");
	endtask
	task cmp_ptr(input logic [15:0] e, input logic [15:0] g);
		cmp(e, g, "pointer value");
	endtask
	task cmp_ext(input logic [15:0] e, input logic [15:0] g);
		cmp(e, g, "external register");
	endtask
	task final_report;
		// An answer that never came leaves its note behind
		if (qp.size() + qd.size() + qx.size() + qr.size() + qe.size()
			+ qv.size() + qa.size() != 0) fail_note("answers missing");
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(negedge sys_clk) begin
		if (prog_valid_ff) cmp_prog(qp.pop_front(), prog_data_ff);
		if (prog_valid_ff) cmp_pa(qa.pop_front(), prog_pin_addr_ff);
		if (start_valid_ff) cmp_vec(qv.pop_front(), start_addr_ff);
		if (start_valid_ff) cmp_pa(qa.pop_front(), prog_pin_addr_ff);
		if (vec_valid_ff) cmp_vec(qv.pop_front(), vec_addr_ff);
		if (vec_valid_ff) cmp_pa(qa.pop_front(), prog_pin_addr_ff);
		if (dm_valid_ff) cmp_data(qd.pop_front(), dm_rdata_ff);
		if (xy_valid_ff) cmp_xy(qx.pop_front(), xin_ff);
		if (xy_valid_ff) cmp_xy(qx.pop_front(), yin_ff);
		if (ptr_valid_ff) cmp_ptr(qr.pop_front(), ptr_rdata_ff);
		if (ext_done_ff && erd) cmp_ext(qe.pop_front(), ext_rdata_ff);
	end
	task fe(input logic q, input logic [15:0] a, input logic [1:0] ix);
		int n;
		int v;
		n = 0;
		v = `DMM_IRQ_VEC_INT + (ix == 2'h3 ? 2 : ix);
		while (prog_busy_ff !== 1'b0 && n < 50) begin tick; n++; end
		if (prog_busy_ff !== 1'b0) fail_note("fetch never idle");
		fetch_req = 1'b1;
		irq_req = q;
		fetch_addr = a;
		irq_idx = ix;
		if (q) qv.push_back(rm[v]);
		else qp.push_back(a > 16'h0FFF ? 16'h0000 : rm[a]);
		qa.push_back(q ? v[15:0] : a);
		tick;
		fetch_req = 1'b0;
		irq_req = 1'b0;
	endtask
	task dm(input logic [1:0] md, input logic [8:0] a, input logic [1:0] mo,
		input logic w, input logic [15:0] d);
		{dm_req, dm_we, dm_mode, dm_addr, dm_ptr_mod} = {1'b1, w, md, a, mo};
		{dm_short, dm_bank, dm_ptr_idx, dm_wdata} = {a[3:0], a[8], a[1:0], d};
		if (!w) qd.push_back(d);
		tick;
		dm_req = 1'b0;
		tick;
	endtask
	task pt(input logic w, input logic b, input logic [1:0] i,
		input logic [15:0] d);
		{ptr_wr, ptr_rd, ptr_bank, ptr_idx, ptr_wdata} = {w, !w, b, i, d};
		if (!w) qr.push_back(d);
		tick;
		{ptr_wr, ptr_rd} = 2'h0;
		tick;
	endtask
	task du(input logic [1:0] mo, input logic [15:0] x, input logic [15:0] y);
		{dual_req, dual_idx_low, dual_idx_high, dual_mod} = {3'h4, 2'h0, mo};
		qx.push_back(x);
		qx.push_back(y);
		tick;
		dual_req = 1'b0;
		tick;
	endtask
	task ex(input logic w, input logic [2:0] s, input logic [15:0] d);
		int n;
		{erd, ext_req, ext_we, ext_sel, ext_wdata} = {!w, 1'b1, w, s, d};
		if (!w) qe.push_back(d);
		tick;
		ext_req = 1'b0;
		n = 0;
		while (ext_done_ff !== 1'b1 && n < 60) begin tick; n++; end
		if (ext_done_ff !== 1'b1) fail_note("ext access never done");
		tick;
	endtask
	initial begin
		{fetch_req, irq_req, irq_idx, fetch_addr, rom_load_addr} = '0;
		{rom_load_data, prog_pin_data, dm_req, dm_we, dm_mode, dm_addr} = '0;
		{dm_short, dm_bank, dm_ptr_idx, dm_ptr_mod, dm_wdata, dual_req} = '0;
		{dual_idx_low, dual_idx_high, dual_mod, ptr_wr, ptr_rd} = '0;
		{ptr_bank, ptr_idx, ptr_wdata, ext_req, ext_we, ext_sel} = '0;
		{ext_wdata, erd} = '0;
		void'($urandom(37750));
		rom_load_en = 1'b1;
		foreach (ra[i]) begin
			rm[ra[i]] = $urandom;
			{rom_load_addr, rom_load_data} = {ra[i][11:0], rm[ra[i]]};
			tick;
		end
		rom_load_en = 1'b0;
		qv.push_back(rm['hFFC]);
		qa.push_back(`DMM_RST_VEC_INT);
		repeat (14) tick;
		resetn = 1'b1;
		foreach (ra[i]) fe(1'b0, ra[i][15:0], 2'h0);
		fe(1'b0, 16'h1000, 2'h0);
		for (int i = 0; i < 4; i++) fe(1'b1, 16'h0000, i[1:0]);
		foreach (da[i]) begin
			m[da[i]] = $urandom;
			dm(`DMM_MODE_DIR, da[i][8:0], `DMM_MOD_NONE, 1'b1, m[da[i]]);
		end
		foreach (da[i]) begin
			dm(`DMM_MODE_DIR, da[i][8:0], 2'h0, 1'b0, m[da[i]]);
		end
		dm(`DMM_MODE_SHORT, 9'h103, 2'h0, 1'b0, m[259]);
		pt(1'b1, 1'b0, 2'h1, {8'($urandom), 8'hFF});
		pt(1'b0, 1'b0, 2'h1, 16'h00FF);
		dm(`DMM_MODE_IND, 9'h001, `DMM_MOD_INC, 1'b0, m[255]);
		pt(1'b0, 1'b0, 2'h1, 16'h0000);
		dm(`DMM_MODE_IND, 9'h001, `DMM_MOD_DEC, 1'b0, m[0]);
		pt(1'b0, 1'b0, 2'h1, 16'h00FF);
		dm(`DMM_MODE_IND, 9'h102, `DMM_MOD_DEC, 1'b0, m[256]);
		pt(1'b0, 1'b1, 2'h2, 16'h00FF);
		pt(1'b1, 1'b0, 2'h0, 16'h00FF);
		du(`DMM_MOD_INC, m[255], m[256]);
		du(`DMM_MOD_NONE, m[0], m[257]);
		for (int i = 0; i < 8; i++) begin
			m[i] = $urandom;
			ex(1'b1, i[2:0], m[i]);
		end
		for (int i = 0; i < 8; i++) ex(1'b0, i[2:0], m[i]);
		// Second reset mid-run: boot again and pointers back to zero
		resetn = 1'b0;
		repeat (3) tick;
		qv.push_back(rm['hFFC]);
		qa.push_back(`DMM_RST_VEC_INT);
		resetn = 1'b1;
		repeat (6) tick;
		pt(1'b0, 1'b0, 2'h1, {8'h00, `DMM_PTR_RST});
		repeat (4) tick;
		final_report;
	end
	initial begin
		#100000;
		failures++;
		final_report;
	end
endmodule
bind dmm_core dmm_checker i_chk (.*);
`default_nettype wire
